// ### rtl/scs_channel_state.sv
`timescale 1ns/1ns
`include "scs_params.svh"

// What this block does
// R1 - Selected package may drive and transmit, subject to arbitration gating.
// R2 - Deselected package keeps drivers off and transmits nothing.
// R3 - With arbitration on, transmit only when selected and holding the token.
// R4 - With arbitration off, transmit whenever selected, token ignored.
// R5 - Package ready accepts and answers package commands and can be selected.
// R6 - Package not ready accepts no package commands.
// R7 - Ready channel accepts commands matching package id plus channel number.
// R8 - Channel not ready accepts no channel commands.
// R9 - Enabled channel may send events and pass-through while package selected.
// R10 - Disabled channel sends no unrequested packets, only command responses.
// R11 - During interface power-up the transmit drivers stay off.
// R12 - Channels enter Initial State within the power-up init timeout.
// R13 - Initial State is left only by the clear-initial-state command.
// R14 - In Initial State a channel still answers commands to its identifier.
// R15 - In Initial State non-vendor channel commands fail with init-required.
// R16 - Entering Initial State disables the channel.
// R17 - Arbitration set enabled only at power-up, otherwise kept.
// R18 - Entering Initial State clears all address and VLAN filter enables.
// R19 - Entering Initial State zeroes all statistics counters.
// R20 - Entering Initial State turns off network transmit of pass-through.
// R21 - Entering Initial State forgets command instance numbers.
// R22 - Entering Initial State stops and clears event notification enables.
// R23 - Channel identifier is package id bits 7:5, channel bits 4:0.
// R24 - Reset-channel command puts that channel in Initial State.
// R25 - Enable and disable commands switch the channel sub-state.
module scs_channel_state #(
    parameter int PWRUP_TIMEOUT_CYC = `SCS_PWRUP_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic arb_token_i,
    input wire logic iface_pwr_i,
    input wire logic [1:0] pkg_id_strap_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_chan_id_i,
    input wire logic [7:0] cmd_type_i,
    input wire logic [7:0] cmd_arg_i,
    input wire logic [7:0] command_instance_number_i,
    input wire logic cmd_oem_i,
    input wire logic resp_pend_i,
    input wire logic [`SCS_NCH-1:0] unreq_req_i,
    input wire logic [`SCS_NCH-1:0] pt_frame_i,
    input wire logic [`SCS_NCH-1:0][7:0] async_event_notification_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic resp_valid_o,
    output logic [15:0] resp_code_o,
    output logic [15:0] resp_reason_o,
    output logic tx_drv_en_o,
    output logic [`SCS_NCH-1:0] unreq_grant_o,
    output logic [`SCS_NCH-1:0] async_event_notification_o,
    output logic [`SCS_NCH-1:0] net_tx_en_o,
    output logic [`SCS_NCH-1:0][7:0] filt_en_o,
    output logic pkg_ready_o,
    output logic selected_o
);
    import scs_pkg::*;

    scs_state_t st_reg;
    scs_state_t st_next;
    logic [`SCS_SY_W-1:0] sy;
    logic link_rise;
    logic tx_allow;
    logic pkg_ready;

    function automatic logic chan_hit(input logic [7:0] id, input logic [2:0] pkg);
        chan_hit = (id[7:5] == pkg) && (id[4:0] < 5'(`SCS_NCH));
    endfunction

    function automatic logic pkg_hit(input logic [7:0] id, input logic [2:0] pkg);
        pkg_hit = (id[7:5] == pkg) && (id[4:0] == `SCS_PKG_CH);
    endfunction

    function automatic scs_state_t enter_init(input scs_state_t s, input int c);
        scs_state_t r;
        r = s;
        r.init[c] = 1'b1;
        r.enabled[c] = 1'b0; // R16
        r.filt_en[c] = 8'h00; // R18
        r.cnt[c] = 16'h0000; // R19
        r.net_tx[c] = 1'b0; // R20
        r.iid_vld[c] = 1'b0; // R21
        r.aen_en[c] = 8'h00; // R22
        return r;
    endfunction

    scs_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({pkg_id_strap_i, iface_pwr_i, arb_token_i, link_clk_i}),
        .q_o(sy)
    );

    assign link_rise = sy[`SCS_SY_LINK] && !st_reg.link_q;
    assign pkg_ready = (st_reg.pwr == SCS_PWR_OPER);
    // R1 R3 R4
    assign tx_allow = pkg_ready && st_reg.selected && (!st_reg.hw_arb_en || sy[`SCS_SY_TOKEN]);
    // Grants are handshakes to the datapath, so they may be combinational
    assign unreq_grant_o = {`SCS_NCH{tx_allow}} & unreq_req_i & st_reg.enabled & ~st_reg.init; // R9 R10

    always_comb begin
        logic [`SCS_NCH-1:0] ent;
        logic [15:0] code;
        logic [15:0] reason;
        logic want;
        int c;
        ent = '0;
        code = `SCS_RESP_OK;
        reason = `SCS_REASON_NONE;
        want = 1'b0;
        c = 0;
        st_next = st_reg;
        st_next.resp_valid = 1'b0;
        st_next.link_q = sy[`SCS_SY_LINK];
        st_next.rdata = 32'h0000_0000;

        case (st_reg.pwr)
            SCS_PWR_DOWN: begin
                st_next.selected = 1'b0;
                st_next.pu_cnt = 16'h0000;
                if (sy[`SCS_SY_PWR]) begin
                    st_next.pwr = SCS_PWR_UP;
                    st_next.settle = 5'h00;
                    // Upper package id bit is fixed at zero
                    st_next.pkg_id = {1'b0, sy[`SCS_SY_STRAP]};
                    st_next.hw_arb_en = st_reg.arb_sup; // R17
                end
            end
            SCS_PWR_UP: begin
                st_next.pu_cnt = st_reg.pu_cnt + 16'h0001;
                if (st_reg.settle == `SCS_SETTLE_CYC - 5'h01) begin
                    st_next.pwr = SCS_PWR_OPER;
                    ent = '1; // R12
                end else begin
                    st_next.settle = st_reg.settle + 5'h01;
                end
            end
            SCS_PWR_OPER: begin
                if (!sy[`SCS_SY_PWR]) begin
                    st_next.pwr = SCS_PWR_DOWN;
                end
            end
            default: st_next.pwr = SCS_PWR_DOWN;
        endcase

        for (int i = 0; i < `SCS_NCH; i++) begin
            if (pt_frame_i[i]) begin
                st_next.cnt[i] = st_reg.cnt[i] + 16'h0001;
            end
        end

        if (wr_i && addr_i == `SCS_REG_CTRL) begin
            st_next.arb_sup = wdata_i[`SCS_CTRL_ARB_SUP];
            // Models a loss of configuration; arbitration setting survives
            if (wdata_i[`SCS_CTRL_ASYNC_RST] && pkg_ready) begin
                ent = '1; // R17
            end
        end

        if (rd_i) begin
            if (addr_i == `SCS_REG_CTRL) begin
                st_next.rdata = {31'h0000_0000, st_reg.arb_sup};
            end else if (addr_i == `SCS_REG_STATUS) begin
                st_next.rdata = {18'h00000, st_reg.net_tx, st_reg.enabled, st_reg.init, st_reg.pkg_id,
                                 st_reg.hw_arb_en, st_reg.selected, pkg_ready, st_reg.pwr};
            end else if (addr_i == `SCS_REG_CNT0) begin
                st_next.rdata = {16'h0000, st_reg.cnt[0]};
            end else if (addr_i == `SCS_REG_CNT1) begin
                st_next.rdata = {16'h0000, st_reg.cnt[1]};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end

        // Nothing is accepted, and nothing answered, until the package is ready
        if (cmd_valid_i && pkg_ready) begin // R6 R8
            if (pkg_hit(cmd_chan_id_i, st_reg.pkg_id)) begin // R5 R23
                st_next.resp_valid = 1'b1;
                if (cmd_type_i == `SCS_CMD_SELECT) begin
                    st_next.selected = 1'b1;
                end else if (cmd_type_i == `SCS_CMD_DESELECT) begin
                    st_next.selected = 1'b0;
                end else begin
                    code = `SCS_RESP_FAIL;
                    reason = `SCS_REASON_UNSUP;
                end
            end else if (chan_hit(cmd_chan_id_i, st_reg.pkg_id)) begin // R7 R14 R23
                c = int'(cmd_chan_id_i[4:0]);
                st_next.resp_valid = 1'b1;
                if (st_reg.iid_vld[c] && st_reg.command_instance_number[c] == command_instance_number_i) begin
                    // Retry: repeat the answer, do not execute again
                    code = st_reg.last_code[c];
                    reason = st_reg.last_reason[c];
                end else begin
                    st_next.iid_vld[c] = 1'b1;
                    st_next.command_instance_number[c] = command_instance_number_i;
                    if (st_reg.init[c] && cmd_type_i != `SCS_CMD_CLEAR_INIT && !cmd_oem_i) begin
                        code = `SCS_RESP_FAIL; // R15
                        reason = `SCS_REASON_INIT_REQ;
                    end else if (!cmd_oem_i) begin
                        case (cmd_type_i)
                            `SCS_CMD_CLEAR_INIT: st_next.init[c] = 1'b0; // R13
                            `SCS_CMD_CH_ENABLE: st_next.enabled[c] = 1'b1; // R25
                            `SCS_CMD_CH_DISABLE: st_next.enabled[c] = 1'b0; // R25
                            `SCS_CMD_CH_RESET: ent[c] = 1'b1; // R24
                            `SCS_CMD_NET_TX_ON: st_next.net_tx[c] = 1'b1;
                            `SCS_CMD_NET_TX_OFF: st_next.net_tx[c] = 1'b0;
                            `SCS_CMD_SET_AEN: st_next.aen_en[c] = cmd_arg_i;
                            `SCS_CMD_SET_FILT: st_next.filt_en[c] = cmd_arg_i;
                            default: begin
                                code = `SCS_RESP_FAIL;
                                reason = `SCS_REASON_UNSUP;
                            end
                        endcase
                    end
                    st_next.last_code[c] = code;
                    st_next.last_reason[c] = reason;
                end
            end
        end
        st_next.resp_code = code;
        st_next.resp_reason = reason;

        // Entry wins over any counter or configuration update this cycle
        for (int i = 0; i < `SCS_NCH; i++) begin
            if (ent[i]) begin
                st_next = enter_init(st_next, i);
            end
        end

        // Drivers turn on only at a rising link clock edge but drop at once
        want = (st_next.pwr == SCS_PWR_OPER) && st_next.selected // R2 R11
               && (!st_next.hw_arb_en || sy[`SCS_SY_TOKEN]) // R3 R4
               && (resp_pend_i || |(unreq_req_i & st_next.enabled & ~st_next.init));
        st_next.drv_en = want && (st_reg.drv_en || link_rise); // R1
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        for (int i = 0; i < `SCS_NCH; i++) begin
            async_event_notification_o[i] = |(async_event_notification_i[i] & st_reg.aen_en[i])
                                            && st_reg.enabled[i] && !st_reg.init[i]; // R10 R22
        end
    end

    assign rdata_o = st_reg.rdata;
    assign resp_valid_o = st_reg.resp_valid;
    assign resp_code_o = st_reg.resp_code;
    assign resp_reason_o = st_reg.resp_reason;
    assign tx_drv_en_o = st_reg.drv_en;
    assign net_tx_en_o = st_reg.net_tx;
    assign filt_en_o = st_reg.filt_en;
    assign pkg_ready_o = pkg_ready;
    assign selected_o = st_reg.selected;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_reset_ch0;
        cmd_valid_i && pkg_ready && cmd_chan_id_i == {st_reg.pkg_id, 5'h00}
        && cmd_type_i == `SCS_CMD_CH_RESET && !cmd_oem_i && !st_reg.init[0]
        && !(st_reg.iid_vld[0] && st_reg.command_instance_number[0] == command_instance_number_i);
    endsequence

    sequence s_init_cleared0;
        st_reg.init[0] && !st_reg.enabled[0] && st_reg.filt_en[0] == 8'h00 && st_reg.cnt[0] == 16'h0000
        && !st_reg.net_tx[0] && st_reg.aen_en[0] == 8'h00 && st_reg.iid_vld[0] == 1'b0;
    endsequence

    sequence s_init_cmd0;
        cmd_valid_i && pkg_ready && cmd_chan_id_i == {st_reg.pkg_id, 5'h00} && st_reg.init[0]
        && cmd_type_i != `SCS_CMD_CLEAR_INIT && !cmd_oem_i
        && !(st_reg.iid_vld[0] && st_reg.command_instance_number[0] == command_instance_number_i);
    endsequence

    desel_drv_off_a: assert property (!st_reg.selected |-> !tx_drv_en_o) // R2
        else $error("drivers on while deselected");
    arb_token_gate_a: assert property (tx_drv_en_o && st_reg.hw_arb_en |-> $past(sy[`SCS_SY_TOKEN])) // R3
        else $error("drivers on without arbitration token");
    no_arb_drive_a: assert property (pkg_ready && sy[`SCS_SY_PWR] && st_reg.selected && !st_reg.hw_arb_en && resp_pend_i
                                     && link_rise && !cmd_valid_i && !wr_i |=> tx_drv_en_o) // R4
        else $error("drivers stayed off with arbitration disabled");
    unreq_gate_a: assert property (unreq_grant_o[0] |-> st_reg.enabled[0] && !st_reg.init[0] && st_reg.selected) // R10
        else $error("unrequested packet granted to disabled channel");
    init_fail_resp_a: assert property (s_init_cmd0 |=> resp_valid_o && resp_code_o == `SCS_RESP_FAIL
                                       && resp_reason_o == `SCS_REASON_INIT_REQ) // R15
        else $error("initial state command not failed with init required");
    reset_enters_init_a: assert property (s_reset_ch0 |=> s_init_cleared0) // R24
        else $error("reset channel did not restore initial state");
    arb_kept_a: assert property (s_reset_ch0 |=> st_reg.hw_arb_en == $past(st_reg.hw_arb_en)) // R17
        else $error("arbitration setting changed on channel reset");
    init_exit_clear_a: assert property ($fell(st_reg.init[0]) |-> $past(cmd_valid_i
                                        && cmd_type_i == `SCS_CMD_CLEAR_INIT)) // R13
        else $error("initial state left without clear command");
    pwrup_timeout_a: assert property (st_reg.pwr == SCS_PWR_UP |-> 32'(st_reg.pu_cnt) < PWRUP_TIMEOUT_CYC) // R12
        else $error("power-up init timeout exceeded");
    pwrup_drv_off_a: assert property (st_reg.pwr != SCS_PWR_OPER |=> !tx_drv_en_o) // R11
        else $error("drivers enabled before operational");
    not_ready_silent_a: assert property (!pkg_ready && cmd_valid_i |=> !resp_valid_o) // R6
        else $error("command answered while not ready");
endmodule // scs_channel_state

// ### rtl/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

`define SCS_NCH 2
`define SCS_PKG_CH 5'h1f
`define SCS_CLK_MHZ 10
`define SCS_PWRUP_TIMEOUT_US 1000
`define SCS_PWRUP_TIMEOUT_CYC (`SCS_PWRUP_TIMEOUT_US * `SCS_CLK_MHZ)
`define SCS_SETTLE_CYC 5'h10

`define SCS_SY_W 5
`define SCS_SY_LINK 0
`define SCS_SY_TOKEN 1
`define SCS_SY_PWR 2
`define SCS_SY_STRAP 4:3

`define SCS_CMD_CLEAR_INIT 8'h00
`define SCS_CMD_SELECT 8'h01
`define SCS_CMD_DESELECT 8'h02
`define SCS_CMD_CH_ENABLE 8'h03
`define SCS_CMD_CH_DISABLE 8'h04
`define SCS_CMD_CH_RESET 8'h05
`define SCS_CMD_NET_TX_ON 8'h06
`define SCS_CMD_NET_TX_OFF 8'h07
`define SCS_CMD_SET_AEN 8'h08
`define SCS_CMD_SET_FILT 8'h09

`define SCS_RESP_OK 16'h0000
`define SCS_RESP_FAIL 16'h0001
`define SCS_REASON_NONE 16'h0000
`define SCS_REASON_INIT_REQ 16'h0001
`define SCS_REASON_UNSUP 16'h0002

`define SCS_REG_CTRL 8'h00
`define SCS_REG_STATUS 8'h04
`define SCS_REG_CNT0 8'h08
`define SCS_REG_CNT1 8'h0c
`define SCS_CTRL_ARB_SUP 0
`define SCS_CTRL_ASYNC_RST 1
`define SCS_CTRL_RESET 1'b1

`endif

// ### rtl/scs_pkg.sv
`include "scs_params.svh"

package scs_pkg;
    typedef enum logic [1:0] {SCS_PWR_DOWN, SCS_PWR_UP, SCS_PWR_OPER} scs_pwr_t;

    typedef struct packed {
        logic [`SCS_SY_W-1:0] s1;
        logic [`SCS_SY_W-1:0] s2;
    } scs_sync_t;

    typedef struct packed {
        scs_pwr_t pwr;
        logic [4:0] settle;
        logic [15:0] pu_cnt;
        logic [2:0] pkg_id;
        logic selected;
        logic hw_arb_en;
        logic arb_sup;
        logic link_q;
        logic drv_en;
        logic [`SCS_NCH-1:0] init;
        logic [`SCS_NCH-1:0] enabled;
        logic [`SCS_NCH-1:0] net_tx;
        logic [`SCS_NCH-1:0][7:0] aen_en;
        logic [`SCS_NCH-1:0][7:0] filt_en;
        logic [`SCS_NCH-1:0][15:0] cnt;
        logic [`SCS_NCH-1:0] iid_vld;
        logic [`SCS_NCH-1:0][7:0] command_instance_number;
        logic [`SCS_NCH-1:0][15:0] last_code;
        logic [`SCS_NCH-1:0][15:0] last_reason;
        logic resp_valid;
        logic [15:0] resp_code;
        logic [15:0] resp_reason;
        logic [31:0] rdata;
    } scs_state_t;
endpackage

// ### rtl/scs_sync.sv
`timescale 1ns/1ns
`include "scs_params.svh"

module scs_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`SCS_SY_W-1:0] d_i,
    output logic [`SCS_SY_W-1:0] q_o
);
    import scs_pkg::*;

    scs_sync_t sy_reg;
    scs_sync_t sy_next;

    always_comb begin
        sy_next = sy_reg;
        sy_next.s1 = d_i;
        sy_next.s2 = sy_reg.s1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sy_reg <= '0;
        end else begin
            sy_reg <= sy_next;
        end
    end

    assign q_o = sy_reg.s2;
endmodule // scs_sync

// ### tb/scs_mc_model.sv
`timescale 1ns/1ns
`include "scs_params.svh"

module scs_mc_model (
    input wire logic clk_i,
    output logic link_clk_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_chan_id_o,
    output logic [7:0] cmd_type_o,
    output logic [7:0] cmd_arg_o,
    output logic [7:0] cmd_iid_o,
    output logic cmd_oem_o,
    input wire logic resp_valid_i,
    input wire logic [15:0] resp_code_i,
    input wire logic [15:0] resp_reason_i
);
    // Reference clock runs free at eight clk_i periods; odd offset keeps its edges 13 ns clear of clk_i edges
    initial begin
        link_clk_o = 1'b0;
        cmd_valid_o = 1'b0;
        {cmd_chan_id_o, cmd_type_o, cmd_arg_o, cmd_iid_o, cmd_oem_o} = '0;
        #137;
        forever #400 link_clk_o = ~link_clk_o;
    end

    // One-cycle command pulse; clear and enable commands also travel here
    task automatic send(input logic [7:0] id, input logic [7:0] typ, input logic [7:0] arg,
                        input logic [7:0] command_instance_number, input logic oem, output logic got, output logic [31:0] resp);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_chan_id_o <= id;
        cmd_type_o <= typ;
        cmd_arg_o <= arg;
        cmd_iid_o <= command_instance_number;
        cmd_oem_o <= oem;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        // Released fields flip so stale values are never mistaken for live ones
        cmd_chan_id_o <= ~id;
        cmd_type_o <= ~typ;
        cmd_arg_o <= ~arg;
        cmd_iid_o <= ~command_instance_number;
        cmd_oem_o <= ~oem;
        #1;
        got = resp_valid_i;
        resp = {resp_code_i, resp_reason_i};
    endtask
endmodule // scs_mc_model

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "scs_params.svh"

module testbench;
    localparam logic [31:0] OK = {`SCS_RESP_OK, `SCS_REASON_NONE};
    localparam logic [31:0] FI = {`SCS_RESP_FAIL, `SCS_REASON_INIT_REQ};
    localparam logic [31:0] UN = {`SCS_RESP_FAIL, `SCS_REASON_UNSUP};
    logic clk = 1'b0, rst_n = 1'b0, link_clk, token = 1'b0, pwr = 1'b0, resp_pend = 1'b0;
    logic [1:0] strap, unreq_req = 2'b00, pt_frame = 2'b00;
    logic [`SCS_NCH-1:0][7:0] aen_in = '0;
    logic cmd_valid, cmd_oem, wr = 1'b0, rd = 1'b0, resp_valid, tx_drv, pkg_ready, selected;
    logic [7:0] cmd_id, cmd_type, cmd_arg, cmd_iid, addr = 8'h00, iid_n, m, f;
    logic [31:0] wdata = 32'h0, rdata, d, seed = 32'd12;
    logic [15:0] resp_code, resp_reason;
    logic [1:0] grant, aen_out, net_tx;
    logic [`SCS_NCH-1:0][7:0] filt;
    logic [2:0] pid;
    logic any;
    int err_total = 0, comparisons = 0, n;

    always #50 clk = ~clk;

    scs_mc_model mc (.clk_i(clk), .link_clk_o(link_clk), .cmd_valid_o(cmd_valid), .cmd_chan_id_o(cmd_id),
        .cmd_type_o(cmd_type), .cmd_arg_o(cmd_arg), .cmd_iid_o(cmd_iid), .cmd_oem_o(cmd_oem),
        .resp_valid_i(resp_valid), .resp_code_i(resp_code), .resp_reason_i(resp_reason));

    scs_channel_state #(.PWRUP_TIMEOUT_CYC(64)) DUT (.clk_i(clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .arb_token_i(token), .iface_pwr_i(pwr), .pkg_id_strap_i(strap), .cmd_valid_i(cmd_valid),
        .cmd_chan_id_i(cmd_id), .cmd_type_i(cmd_type), .cmd_arg_i(cmd_arg), .command_instance_number_i(cmd_iid),
        .cmd_oem_i(cmd_oem), .resp_pend_i(resp_pend), .unreq_req_i(unreq_req), .pt_frame_i(pt_frame),
        .async_event_notification_i(aen_in), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .resp_valid_o(resp_valid), .resp_code_o(resp_code), .resp_reason_o(resp_reason),
        .tx_drv_en_o(tx_drv), .unreq_grant_o(grant), .async_event_notification_o(aen_out),
        .net_tx_en_o(net_tx), .filt_en_o(filt), .pkg_ready_o(pkg_ready), .selected_o(selected));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] st(input logic rdy, input logic sel, input logic arb, input logic [1:0] ini,
                                       input logic [1:0] en, input logic [1:0] nt);
        return {18'h0, nt, en, ini, pid, arb, sel, rdy, 2'd2};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic cmd(input logic [7:0] id, input logic [7:0] typ, input logic [7:0] arg, input logic oem,
                       input logic ans, input logic [31:0] exp);
        logic got;
        logic [31:0] resp;
        mc.send(id, typ, arg, iid_n, oem, got, resp);
        iid_n = iid_n + 8'h01;
        check("resp_valid", {31'h0, got}, {31'h0, ans});
        if (ans)
            check("resp_code", resp, exp);
    endtask

    // Collects whether the drivers came on at any point over cyc cycles
    task automatic drv_watch(input int cyc);
        any = 1'b0;
        repeat (cyc) begin
            @(posedge clk);
            #1;
            any = any | tx_drv;
        end
    endtask

    task automatic power_up();
        @(posedge clk);
        pwr <= 1'b1;
        n = 0;
        while (pkg_ready !== 1'b1 && n < 64) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("pkg_ready", {31'h0, pkg_ready}, 32'h1);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        strap = 2'(rnd());
        pid = {1'b0, strap};
        iid_n = 8'(rnd());
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wreg(`SCS_REG_CTRL, 32'h1);
        @(posedge clk);
        pwr <= 1'b1;
        resp_pend <= 1'b1;
        cmd({pid, 5'h1f}, `SCS_CMD_SELECT, 8'h00, 1'b0, 1'b0, OK);
        drv_watch(8);
        check("drv_pwrup", {31'h0, any}, 32'h0);
        power_up();
        rreg(`SCS_REG_STATUS, d);
        check("status_up", d, st(1, 0, 1, 2'b11, 2'b00, 2'b00));
        $display("test power_up done");

        cmd({pid, 5'h00}, `SCS_CMD_SET_AEN, 8'hff, 1'b0, 1'b1, FI);
        cmd({pid, 5'h01}, `SCS_CMD_CH_ENABLE, 8'h00, 1'b0, 1'b1, FI);
        cmd({pid, 5'h00}, 8'h5a, 8'h00, 1'b1, 1'b1, OK);
        cmd({pid, 5'h1f}, `SCS_CMD_SELECT, 8'h00, 1'b0, 1'b1, OK);
        cmd({pid, 5'h1f}, `SCS_CMD_CH_ENABLE, 8'h00, 1'b0, 1'b1, UN);
        cmd({~pid, 5'h00}, `SCS_CMD_CLEAR_INIT, 8'h00, 1'b0, 1'b0, OK);
        cmd({pid, 5'h02}, `SCS_CMD_CLEAR_INIT, 8'h00, 1'b0, 1'b0, OK);
        cmd({pid, 5'h00}, `SCS_CMD_CLEAR_INIT, 8'h00, 1'b0, 1'b1, OK);
        cmd({pid, 5'h00}, 8'h3c, 8'h00, 1'b0, 1'b1, UN);
        $display("test initial_state done");

        cmd({pid, 5'h00}, `SCS_CMD_CH_ENABLE, 8'h00, 1'b0, 1'b1, OK);
        m = 8'(rnd()) | 8'h01;
        cmd({pid, 5'h00}, `SCS_CMD_SET_AEN, m, 1'b0, 1'b1, OK);
        @(posedge clk);
        aen_in <= {8'hff, m};
        unreq_req <= 2'b10;
        @(posedge clk);
        #1;
        check("aen_out", {30'h0, aen_out}, 32'h1);
        check("grant_ch1", {31'h0, grant[1]}, 32'h0);
        f = 8'(rnd());
        cmd({pid, 5'h00}, `SCS_CMD_SET_FILT, f, 1'b0, 1'b1, OK);
        check("filt", {24'h0, filt[0]}, {24'h0, f});
        cmd({pid, 5'h00}, `SCS_CMD_NET_TX_ON, 8'h00, 1'b0, 1'b1, OK);
        check("net_tx", {30'h0, net_tx}, 32'h1);
        cmd({pid, 5'h00}, `SCS_CMD_NET_TX_OFF, 8'h00, 1'b0, 1'b1, OK);
        check("net_tx_off", {30'h0, net_tx}, 32'h0);
        cmd({pid, 5'h00}, `SCS_CMD_NET_TX_ON, 8'h00, 1'b0, 1'b1, OK);
        n = 3 + (rnd() & 32'h7);
        repeat (n) begin
            @(posedge clk);
            pt_frame <= 2'b11;
            @(posedge clk);
            pt_frame <= 2'b00;
        end
        rreg(`SCS_REG_CNT0, d);
        check("cnt0", d, n);
        rreg(`SCS_REG_CNT1, d);
        check("cnt1", d, n);
        iid_n = iid_n - 8'h01;
        cmd({pid, 5'h00}, `SCS_CMD_CH_DISABLE, 8'h00, 1'b0, 1'b1, OK);
        rreg(`SCS_REG_STATUS, d);
        check("status_en", d, st(1, 1, 1, 2'b10, 2'b01, 2'b01));
        $display("test enabled done");

        cmd({pid, 5'h00}, `SCS_CMD_CH_RESET, 8'h00, 1'b0, 1'b1, OK);
        check("filt_rst", {24'h0, filt[0]}, 32'h0);
        check("net_tx_rst", {30'h0, net_tx}, 32'h0);
        check("aen_rst", {30'h0, aen_out}, 32'h0);
        rreg(`SCS_REG_CNT0, d);
        check("cnt0_rst", d, 32'h0);
        rreg(`SCS_REG_STATUS, d);
        check("status_rst", d, st(1, 1, 1, 2'b11, 2'b00, 2'b00));
        iid_n = iid_n - 8'h01;
        cmd({pid, 5'h00}, `SCS_CMD_CLEAR_INIT, 8'h00, 1'b0, 1'b1, OK);
        rreg(`SCS_REG_STATUS, d);
        check("status_clr", d, st(1, 1, 1, 2'b10, 2'b00, 2'b00));
        cmd({pid, 5'h00}, `SCS_CMD_CH_ENABLE, 8'h00, 1'b0, 1'b1, OK);
        check("aen_cleared", {30'h0, aen_out}, 32'h0);
        $display("test channel_reset done");

        drv_watch(40);
        check("drv_no_token", {31'h0, any}, 32'h0);
        @(posedge clk);
        token <= 1'b1;
        drv_watch(30);
        check("drv_token", {31'h0, any}, 32'h1);
        unreq_req <= 2'b11;
        @(posedge clk);
        #1;
        check("grant", {30'h0, grant}, 32'h1);
        cmd({pid, 5'h00}, `SCS_CMD_CH_DISABLE, 8'h00, 1'b0, 1'b1, OK);
        check("grant_dis", {30'h0, grant}, 32'h0);
        cmd({pid, 5'h1f}, `SCS_CMD_DESELECT, 8'h00, 1'b0, 1'b1, OK);
        check("selected", {31'h0, selected}, 32'h0);
        @(posedge clk);
        drv_watch(30);
        check("drv_desel", {31'h0, any}, 32'h0);
        wreg(`SCS_REG_CTRL, 32'h2);
        rreg(`SCS_REG_STATUS, d);
        check("status_async", d, st(1, 0, 1, 2'b11, 2'b00, 2'b00));
        rreg(`SCS_REG_CNT1, d);
        check("cnt1_async", d, 32'h0);
        $display("test arbitration done");

        @(posedge clk);
        pwr <= 1'b0;
        token <= 1'b0;
        repeat (10) @(posedge clk);
        power_up();
        rreg(`SCS_REG_STATUS, d);
        check("status_repwr", d, st(1, 0, 0, 2'b11, 2'b00, 2'b00));
        cmd({pid, 5'h1f}, `SCS_CMD_SELECT, 8'h00, 1'b0, 1'b1, OK);
        drv_watch(30);
        check("drv_arb_off", {31'h0, any}, 32'h1);
        $display("test arb_off done");
        results();
    end
endmodule // testbench
